// file: hw/qdnv_defs.vh
`ifndef QDNV_DEFS_VH
`define QDNV_DEFS_VH

// ==========================================
// Serial word layout
`define QDNV_WORD_BITS      14
`define QDNV_CNT_W          4
`define QDNV_START_POS      13
`define QDNV_CMD_HI         12
`define QDNV_CMD_LO         11
`define QDNV_ADDR_HI        10
`define QDNV_ADDR_LO        8
`define QDNV_DATA_HI        7
`define QDNV_DATA_LO        0

// ==========================================
// Commands
`define QDNV_CMD_NV_WRITE   2'h0
`define QDNV_CMD_VOL_WRITE  2'h1
`define QDNV_CMD_NV_READ    2'h2
`define QDNV_CMD_NV_LOAD    2'h3

// ==========================================
// Register targets
`define QDNV_ADDR_CH0       3'h0
`define QDNV_ADDR_CH3       3'h3
`define QDNV_ADDR_MUTE_SHDN 3'h4
`define QDNV_NUM_TARGETS    5

// ==========================================
// Mute/shutdown field positions
`define QDNV_MUTE_HI        7
`define QDNV_MUTE_LO        4
`define QDNV_SHDN_HI        3
`define QDNV_SHDN_LO        0

// ==========================================
// Reset values
`define QDNV_CODE_RESET     8'h00
`define QDNV_MSR_RESET      8'h00

// ==========================================
// Timing
`define QDNV_CLK_KHZ        20000
`define QDNV_STORE_TIME_US  13000
`define QDNV_STORE_CYCLES   ((`QDNV_STORE_TIME_US * `QDNV_CLK_KHZ) / 1000)

`endif

// file: hw/qdnv_nv_store.v
`timescale 1ns/1ps
`include "qdnv_defs.vh"

// ==========================================
// Nonvolatile store: five bytes, registered read
module qdnv_nv_store (
  // Clock
  input  wire       clk,
  // Access port
  input  wire [2:0] addr,
  input  wire       wrEn,
  input  wire [7:0] wrData,
  input  wire       rdEn,
  output reg  [7:0] rdData
);

  reg [7:0] cells [0:`QDNV_NUM_TARGETS-1];
  integer   i;

  // Blank array as delivered
  initial begin
    for (i = 0; i < `QDNV_NUM_TARGETS; i = i + 1) begin
      cells[i] = 8'h00;
    end
  end

  // Write and registered read, no reset on contents
  always @(posedge clk) begin
    if (wrEn) begin
      cells[addr] <= wrData;
    end
    if (rdEn) begin
      rdData <= cells[addr];
    end
  end

endmodule // qdnv_nv_store

// file: hw/qdnv_control.v
// Function
// - Shift 14 bits, decode, route data byte
// - Volatile write updates output; nonvolatile only stores
// - Clear volatile on shutdown/power loss
// - Power-up copies nonvolatile into volatile registers
// - Nonvolatile readable on serial output only
// - Five nonvolatile registers: four codes, mute/shutdown
// - Four volatile, four nonvolatile 8-bit codes
// - Volatile code loaded by write or transfer
// - Nonvolatile code transferred or shifted out
// - D7-D4 mute, D3-D0 shutdown, channel 3..0
// - Mute forces low reference; shutdown gives hi-Z
// - Mute pin mutes all channels together
// - Open-drain idle flag reports memory busy
// - Word: start, command, address, data; 00 stores
// - Command 01 writes volatile, updates that output
// - Command 10 presents nonvolatile on serial output
// - Command 11 copies nonvolatile into volatile

`timescale 1ns/1ps
`include "qdnv_defs.vh"

module qdnv_control #(
  parameter STORE_CYCLES = `QDNV_STORE_CYCLES
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // Serial port pins
  input  wire        serialClk,
  input  wire        chipSelect_b,
  input  wire        serialDataIn,
  output wire        serialDataOut,
  output wire        serialDataOutOe,
  // Pin-level control
  input  wire        muteAll,
  output wire        nvMemoryIdleFlagOut,
  output wire        nvMemoryIdleFlagOe,
  // Converter controls
  output reg  [7:0]  channelCode0,
  output reg  [7:0]  channelCode1,
  output reg  [7:0]  channelCode2,
  output reg  [7:0]  channelCode3,
  output reg  [3:0]  channelForceLow,
  output reg  [3:0]  channelHighZ
);

  localparam ST_PWR_RD = 3'h0;
  localparam ST_PWR_LD = 3'h1;
  localparam ST_IDLE   = 3'h2;
  localparam ST_RD     = 3'h3;
  localparam ST_LD     = 3'h4;

  // ==========================================
  // Pin synchronisers
  reg  [1:0] sclkSync;
  reg  [1:0] csSync;
  reg  [1:0] dinSync;
  reg  [1:0] muteSync;
  reg        sclkPrev_reg;
  reg        csPrev_reg;

  // Two flops per pin
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkSync     <= 2'h0;
      csSync       <= 2'h3;
      dinSync      <= 2'h0;
      muteSync     <= 2'h0;
      sclkPrev_reg <= 1'b0;
      csPrev_reg   <= 1'b1;
    end else begin
      sclkSync     <= {sclkSync[0], serialClk};
      csSync       <= {csSync[0], chipSelect_b};
      dinSync      <= {dinSync[0], serialDataIn};
      muteSync     <= {muteSync[0], muteAll};
      sclkPrev_reg <= sclkSync[1];
      csPrev_reg   <= csSync[1];
    end
  end

  wire sclkRise = sclkSync[1] & ~sclkPrev_reg;
  wire sclkFall = ~sclkSync[1] & sclkPrev_reg;
  wire selected = ~csSync[1];
  wire csRelease = csSync[1] & ~csPrev_reg;

  // ==========================================
  // Input shift register and bit counter
  reg  [`QDNV_WORD_BITS-1:0] shift_reg;
  reg  [`QDNV_CNT_W-1:0]     bitCount_reg;

  // Capture on rising serial clock while selected
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg    <= {`QDNV_WORD_BITS{1'b0}};
      bitCount_reg <= {`QDNV_CNT_W{1'b0}};
    end else if (!selected) begin
      bitCount_reg <= {`QDNV_CNT_W{1'b0}};
    end else if (sclkRise) begin
      shift_reg <= {shift_reg[`QDNV_WORD_BITS-2:0], dinSync[1]};
      if (bitCount_reg != {`QDNV_CNT_W{1'b1}}) begin
        bitCount_reg <= bitCount_reg + 4'h1;
      end
    end
  end

  // Word decode
  wire [1:0] wordCmd  = shift_reg[`QDNV_CMD_HI:`QDNV_CMD_LO];
  wire [2:0] wordAddr = shift_reg[`QDNV_ADDR_HI:`QDNV_ADDR_LO];
  wire [7:0] wordData = shift_reg[`QDNV_DATA_HI:`QDNV_DATA_LO];
  wire wordValid = csRelease && (bitCount_reg == `QDNV_WORD_BITS)
                   && shift_reg[`QDNV_START_POS] && (wordAddr <= `QDNV_ADDR_MUTE_SHDN);

  // ==========================================
  // Control state and storage timer
  reg  [2:0]  state_reg;
  reg  [2:0]  nvAddr_reg;
  reg  [31:0] busyCount_reg;
  wire [31:0] volCodes;
  reg  [7:0]  volMsr_reg;
  reg  [7:0]  doutShift_reg;
  wire [7:0]  nvRdData;
  wire        busy = (busyCount_reg != 32'h0);

  // Memory access selection
  wire nvWrite = (state_reg == ST_IDLE) && wordValid && !busy
                 && (wordCmd == `QDNV_CMD_NV_WRITE);
  wire nvRead = (state_reg == ST_PWR_RD)
                || ((state_reg == ST_IDLE) && wordValid
                    && ((wordCmd == `QDNV_CMD_NV_READ) || (wordCmd == `QDNV_CMD_NV_LOAD)));
  wire [2:0] memAddr = (state_reg == ST_IDLE) ? wordAddr : nvAddr_reg;

  // Nonvolatile registers
  qdnv_nv_store uStore (
    .clk    (ref_clk),
    .addr   (memAddr),
    .wrEn   (nvWrite),
    .wrData (wordData),
    .rdEn   (nvRead),
    .rdData (nvRdData)
  );

  // Volatile byte load event
  reg  [2:0] volAddr;
  reg  [7:0] volData;
  reg        volLoad;

  // Select source of a volatile load
  always @* begin
    volLoad = 1'b0;
    volAddr = nvAddr_reg;
    volData = nvRdData;
    if ((state_reg == ST_PWR_LD) || (state_reg == ST_LD)) begin
      volLoad = 1'b1;
    end else if ((state_reg == ST_IDLE) && wordValid && (wordCmd == `QDNV_CMD_VOL_WRITE)) begin
      volLoad = 1'b1;
      volAddr = wordAddr;
      volData = wordData;
    end
  end

  // Sequencer: power-up copy, read and transfer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_PWR_RD;
      nvAddr_reg <= `QDNV_ADDR_CH0;
    end else begin
      case (state_reg)
        ST_PWR_RD: begin
          state_reg <= ST_PWR_LD;
        end
        ST_PWR_LD: begin
          if (nvAddr_reg == `QDNV_ADDR_MUTE_SHDN) begin
            state_reg <= ST_IDLE;
          end else begin
            nvAddr_reg <= nvAddr_reg + 3'h1;
            state_reg  <= ST_PWR_RD;
          end
        end
        ST_IDLE: begin
          nvAddr_reg <= wordAddr;
          if (wordValid && (wordCmd == `QDNV_CMD_NV_READ)) begin
            state_reg <= ST_RD;
          end else if (wordValid && (wordCmd == `QDNV_CMD_NV_LOAD)) begin
            state_reg <= ST_LD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Storage cycle timer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busyCount_reg <= 32'h0;
    end else if (nvWrite) begin
      busyCount_reg <= STORE_CYCLES;
    end else if (busy) begin
      busyCount_reg <= busyCount_reg - 32'h1;
    end
  end

  // ==========================================
  // Volatile registers
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : gVol
      reg [7:0] code_reg;
      // Channel code, cleared by reset or shutdown
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          code_reg <= `QDNV_CODE_RESET;
        end else if (volMsr_reg[`QDNV_SHDN_LO + ch]) begin
          code_reg <= `QDNV_CODE_RESET;
        end else if (volLoad && (volAddr == ch)) begin
          code_reg <= volData;
        end
      end
      // One driver per channel slice
      assign volCodes[8*ch +: 8] = code_reg;
    end
  endgenerate

  // Mute/shutdown volatile register
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      volMsr_reg <= `QDNV_MSR_RESET;
    end else if (volLoad && (volAddr == `QDNV_ADDR_MUTE_SHDN)) begin
      volMsr_reg <= volData;
    end
  end

  // ==========================================
  // Converter control outputs
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      channelCode0    <= `QDNV_CODE_RESET;
      channelCode1    <= `QDNV_CODE_RESET;
      channelCode2    <= `QDNV_CODE_RESET;
      channelCode3    <= `QDNV_CODE_RESET;
      channelForceLow <= 4'h0;
      channelHighZ    <= 4'h0;
    end else begin
      channelCode0    <= volCodes[7:0];
      channelCode1    <= volCodes[15:8];
      channelCode2    <= volCodes[23:16];
      channelCode3    <= volCodes[31:24];
      channelForceLow <= volMsr_reg[`QDNV_MUTE_HI:`QDNV_MUTE_LO] | {4{muteSync[1]}};
      channelHighZ    <= volMsr_reg[`QDNV_SHDN_HI:`QDNV_SHDN_LO];
    end
  end

  // ==========================================
  // Serial output register
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      doutShift_reg <= 8'h00;
    end else if (state_reg == ST_RD) begin
      doutShift_reg <= nvRdData;
    end else if (selected && sclkFall) begin
      doutShift_reg <= {doutShift_reg[6:0], 1'b0};
    end
  end

  assign serialDataOut   = doutShift_reg[7];
  assign serialDataOutOe = selected;

  // Open-drain idle flag: pull low while storing
  assign nvMemoryIdleFlagOut = 1'b0;
  assign nvMemoryIdleFlagOe  = busy;

endmodule // qdnv_control

// file: testbench/qdnv_control_properties.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module qdnv_control_properties #(
  parameter STORE_CYCLES = 20
) (
  // Watched ports
  input wire       ref_clk,
  input wire       rst_b,
  input wire       chipSelect_b,
  input wire       serialDataOutOe,
  input wire       muteAll,
  input wire       nvMemoryIdleFlagOut,
  input wire       nvMemoryIdleFlagOe,
  input wire [7:0] channelCode0,
  input wire [7:0] channelCode3,
  input wire [3:0] channelForceLow,
  input wire [3:0] channelHighZ
);
  // Busy stretch length
  reg [31:0] busyCnt_reg;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      busyCnt_reg <= 32'h0;
    else
      busyCnt_reg <= nvMemoryIdleFlagOe ? busyCnt_reg + 32'h1 : 32'h0;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Pin and output relations
  dout_release_a: assert property (chipSelect_b [*4] |-> !serialDataOutOe)
    else $error("dout enabled while deselected");
  flag_open_drain_a: assert property (!nvMemoryIdleFlagOut && (busyCnt_reg <= STORE_CYCLES))
    else $error("idle flag driven high");
  frame_stable_a: assert property ((!chipSelect_b) [*6] |-> $stable(channelCode0) && $stable(channelCode3))
    else $error("code changed in frame");
  mute_pin_a: assert property (muteAll [*4] |-> channelForceLow == 4'hf)
    else $error("mute pin ignored");
  shdn_clear_a: assert property (channelHighZ[0] [*3] |-> channelCode0 == 8'h00)
    else $error("code kept in shutdown");
  busy_length_a: assert property ($fell(nvMemoryIdleFlagOe) |-> busyCnt_reg == STORE_CYCLES)
    else $error("wrong busy length");
  busy_start_a: assert property ($rose(nvMemoryIdleFlagOe) |-> chipSelect_b)
    else $error("busy began in frame");
  state_change_a: assert property ($changed(channelHighZ) |-> chipSelect_b)
    else $error("shutdown changed in frame");
endmodule // qdnv_control_properties

bind qdnv_control qdnv_control_properties #(.STORE_CYCLES(STORE_CYCLES)) chk_u (
  .ref_clk             (ref_clk),
  .rst_b               (rst_b),
  .chipSelect_b        (chipSelect_b),
  .serialDataOutOe     (serialDataOutOe),
  .muteAll             (muteAll),
  .nvMemoryIdleFlagOut (nvMemoryIdleFlagOut),
  .nvMemoryIdleFlagOe  (nvMemoryIdleFlagOe),
  .channelCode0        (channelCode0),
  .channelCode3        (channelCode3),
  .channelForceLow     (channelForceLow),
  .channelHighZ        (channelHighZ)
);

// file: testbench/qdnv_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host serial master
module qdnv_host_model (
  // Clock
  input  wire ref_clk,
  // Serial pins
  output reg  serialClk,
  output reg  chipSelect_b,
  output reg  serialDataIn,
  input  wire serialDataOut,
  input  wire serialDataOutOe
);
  reg  doutLast = 1'b0;
  // Released data line shows the inverse of its last level
  wire doutLine = serialDataOutOe ? serialDataOut : ~doutLast;
  always @(posedge ref_clk) begin
    if (serialDataOutOe)
      doutLast <= serialDataOut;
  end
  // Idle pins
  initial begin
    serialClk = 1'b0;
    chipSelect_b = 1'b1;
    serialDataIn = 1'b0;
  end
  // Top n bits of w out, MSB first; D7..D0 caught before rising edges
  task automatic frame(input [13:0] w, input integer n, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      @(posedge ref_clk);
      chipSelect_b <= 1'b0;
      for (i = 13; i > 13 - n; i = i - 1) begin
        serialDataIn <= w[i];
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        if (i > 5)
          rd = {rd[6:0], doutLine};
        @(posedge ref_clk);
        serialClk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        serialClk <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      chipSelect_b <= 1'b1;
      serialDataIn <= ~serialDataIn;
      repeat (16) @(posedge ref_clk);
    end
  endtask
endmodule // qdnv_host_model

// file: testbench/qdnv_control_tb.sv
`timescale 1ns/1ps
// ==========================================
// Testbench
module qdnv_control_tb;
  reg         ref_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         muteAll = 1'b0;
  wire        serialClk, chipSelect_b, serialDataIn, serialDataOut, serialDataOutOe;
  wire        nvMemoryIdleFlagOut, nvMemoryIdleFlagOe;
  wire [7:0]  channelCode0, channelCode1, channelCode2, channelCode3;
  wire [3:0]  channelForceLow, channelHighZ;
  reg  [31:0] expAll = 32'h0;
  reg  [7:0]  rdByte;
  integer     failures = 0;
  integer     totalChecks = 0;
  integer     cycles = 0;
  // Pulled-up flag, codes together
  wire        idleFlag = nvMemoryIdleFlagOe ? nvMemoryIdleFlagOut : 1'b1;
  wire [31:0] codesAll = {channelCode3, channelCode2, channelCode1, channelCode0};
  always #25 ref_clk = ~ref_clk;
  qdnv_control #(.STORE_CYCLES(20)) dut_u (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .serialClk           (serialClk),
    .chipSelect_b        (chipSelect_b),
    .serialDataIn        (serialDataIn),
    .serialDataOut       (serialDataOut),
    .serialDataOutOe     (serialDataOutOe),
    .muteAll             (muteAll),
    .nvMemoryIdleFlagOut (nvMemoryIdleFlagOut),
    .nvMemoryIdleFlagOe  (nvMemoryIdleFlagOe),
    .channelCode0        (channelCode0),
    .channelCode1        (channelCode1),
    .channelCode2        (channelCode2),
    .channelCode3        (channelCode3),
    .channelForceLow     (channelForceLow),
    .channelHighZ        (channelHighZ)
  );
  qdnv_host_model host_u (
    .ref_clk         (ref_clk),
    .serialClk       (serialClk),
    .chipSelect_b    (chipSelect_b),
    .serialDataIn    (serialDataIn),
    .serialDataOut   (serialDataOut),
    .serialDataOutOe (serialDataOutOe)
  );
  // Compare one value
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    begin
      totalChecks = totalChecks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // All codes
  task chk_codes;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        cmp("code", expAll[8*i +: 8], codesAll[8*i +: 8]);
    end
  endtask
  // One word, then settle
  task send(input [1:0] c, input [2:0] a, input [7:0] d);
    begin
      host_u.frame({1'b1, c, a, d}, 14, rdByte);
      @(negedge ref_clk);
    end
  endtask
  // Bounded wait for storage end
  task wait_ready;
    integer n;
    begin
      for (n = 0; n < 100 && idleFlag !== 1'b1; n = n + 1)
        @(negedge ref_clk);
      cmp("ready", 8'h01, {7'h0, idleFlag});
    end
  endtask
  // Volatile writes, one channel each
  task t_vol;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        send(2'h1, i[2:0], 8'h5a + i[7:0]);
        expAll[8*i +: 8] = 8'h5a + i[7:0];
        chk_codes;
      end
    end
  endtask
  // Stores, busy flag, read back, load
  task t_nv;
    begin
      send(2'h0, 3'h1, 8'hc3);
      cmp("busy", 8'h00, {7'h0, idleFlag});
      chk_codes;
      wait_ready;
      send(2'h0, 3'h2, 8'h7e);
      wait_ready;
      send(2'h2, 3'h1, 8'hff);
      host_u.frame(14'h0000, 14, rdByte);
      cmp("read", 8'hc3, rdByte);
      send(2'h3, 3'h1, 8'h00);
      expAll[15:8] = 8'hc3;
      chk_codes;
    end
  endtask
  // Mute and shutdown bits, mute pin
  task t_mute;
    begin
      send(2'h1, 3'h4, 8'h21);
      expAll[7:0] = 8'h00;
      cmp("mute", 8'h02, {4'h0, channelForceLow});
      cmp("shdn", 8'h01, {4'h0, channelHighZ});
      chk_codes;
      @(posedge ref_clk);
      muteAll <= 1'b1;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp("mute pin", 8'h0f, {4'h0, channelForceLow});
      @(posedge ref_clk);
      muteAll <= 1'b0;
      send(2'h1, 3'h4, 8'h00);
      cmp("mute", 8'h00, {4'h0, channelForceLow});
      cmp("shdn", 8'h00, {4'h0, channelHighZ});
    end
  endtask
  // Bad start bit, address, length
  task t_refused;
    begin
      host_u.frame({1'b0, 2'h1, 3'h0, 8'hff}, 14, rdByte);
      host_u.frame({1'b1, 2'h1, 3'h5, 8'hff}, 14, rdByte);
      host_u.frame({1'b1, 2'h1, 3'h0, 8'hff}, 13, rdByte);
      @(negedge ref_clk);
      chk_codes;
    end
  endtask
  // Store and read mute/shutdown, power loss, then reload
  task t_power;
    begin
      send(2'h0, 3'h4, 8'h48);
      cmp("shdn", 8'h00, {4'h0, channelHighZ});
      wait_ready;
      send(2'h2, 3'h4, 8'h00);
      host_u.frame(14'h0000, 14, rdByte);
      cmp("read msr", 8'h48, rdByte);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      expAll = 32'h0;
      @(negedge ref_clk);
      chk_codes;
      cmp("shdn", 8'h00, {4'h0, channelHighZ});
      @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (14) @(posedge ref_clk);
      @(negedge ref_clk);
      expAll = 32'h007ec300;
      chk_codes;
      cmp("mute", 8'h04, {4'h0, channelForceLow});
      cmp("shdn", 8'h08, {4'h0, channelHighZ});
    end
  endtask
  // Counts and verdict
  task wrap_up;
    begin
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_vol;
    t_nv;
    t_mute;
    t_refused;
    t_power;
    wrap_up;
  end
  // Cycle ceiling
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
endmodule // qdnv_control_tb
